// [sbc_diag_status.sv]
// Diagnostic status word, fault reactions, wake signalling and the serial port behind them
`timescale 1ns/10ps
`include "sbc_consts.svh"
`default_nettype none
module sbc_diag_status
  import sbc_pkg::*;
#(
  parameter int VMON_STARTUP_CYCLES = 1024
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic chip_select_low,
  input wire logic serial_clock,
  input wire logic serial_data_in,
  output logic serial_data_out,
  output logic serial_data_out_oe_n,
  output logic rxd_force_low,
  input wire logic error_link_in,
  output logic error_link_out,
  output logic error_link_oe_n,
  input wire logic regulator_prewarn,
  input wire logic regulator_overtemp,
  input wire logic regulator_load_low,
  input wire logic led_driver_fault,
  input wire logic low_side_switches_fault,
  input wire logic supply_output_fault,
  input wire logic battery_uv,
  input wire logic battery_ov,
  input wire logic supply_pin_uv,
  input wire logic lin_failure,
  input wire logic lin_wake,
  input wire logic cyclic_wake_expired,
  input wire logic [4:0] monitor_input,
  input wire logic window_guard_reset,
  output logic [1:0] low_side_switches_en,
  output logic supply_output_en,
  output logic led_driver_en,
  output logic regulator_en,
  output logic window_guard_en,
  output logic window_guard_trigger,
  output logic [5:0] window_guard_period,
  output logic [4:0] cyclic_period,
  output logic [8:0] general_config,
  output logic measure_en,
  output logic [2:0] sbc_mode
);

  localparam int VMON_W = $clog2(VMON_STARTUP_CYCLES + 1);

  // Synchronised pins
  logic [2:0] spi_s;
  logic [17:0] flt_s;
  logic cs_s;
  logic sclk_s;
  logic din_s;
  logic prewarn_s;
  logic reg_ot_s;
  logic load_low_s;
  logic led_flt_s;
  logic ls_flt_s;
  logic sup_flt_s;
  logic bat_uv_s;
  logic bat_ov_s;
  logic vs_uv_s;
  logic lin_fail_s;
  logic lin_wake_s;
  logic cyc_exp_s;
  logic err_in_s;
  logic [4:0] mon_s;

  // Serial engine state
  logic cs_prev_q;
  logic sclk_prev_q;
  logic shifting_q;
  logic [`FRAME_CNT_W-1:0] bit_cnt_q;
  logic [`FRAME_BITS-1:0] tx_q;
  logic [`FRAME_BITS-1:0] rx_q;
  logic spi_fail_q;
  logic cs_fall;
  logic cs_rise;
  logic sclk_rise;
  logic sclk_fall;
  logic frame_ok;
  logic [2:0] cw_mode;
  cfg_sel_t cw_sel;

  // Status and control state
  sbc_mode_t mode_q;
  logic [`NUM_FLAGS-1:0] flag_set;
  logic [`NUM_FLAGS-1:0] flag_clr;
  logic [`NUM_FLAGS-1:0] flag_q;
  logic [`FRAME_BITS-1:0] status_word;
  logic vint_ok_q;
  logic led_ovuv_dis_q;
  logic guard_lp_q;
  logic [VMON_W-1:0] vmon_cnt_q;
  logic vmon_ready;
  logic is_active;
  logic power_save;
  logic bat_uv_g;
  logic bat_ov_g;
  logic vs_uv_g;
  logic ls_flt_prev_q;
  logic mcu_err;
  logic [4:0] mon_prev_q;
  logic [4:0] mon_edge;
  logic cyc_wake;
  logic any_wake;
  logic wake_word_q;
  logic wake_read_q;
  logic wake_do_q;
  logic [4:0] wake_mon_q;
  logic wake_lin_q;
  logic wake_cyc_q;

  pin_sync #(
    .WIDTH(3),
    .RST_VAL(`SPI_PINS_RST)
  ) u_spi_sync (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .pin_in({chip_select_low, serial_clock, serial_data_in}),
    .level_q(spi_s)
  );

  pin_sync #(
    .WIDTH(18),
    .RST_VAL(`FAULT_PINS_RST)
  ) u_fault_sync (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .pin_in({regulator_prewarn, regulator_overtemp, regulator_load_low, led_driver_fault,
             low_side_switches_fault, supply_output_fault, battery_uv, battery_ov,
             supply_pin_uv, lin_failure, lin_wake, cyclic_wake_expired, error_link_in,
             monitor_input}),
    .level_q(flt_s)
  );

  assign {cs_s, sclk_s, din_s} = spi_s;
  assign {prewarn_s, reg_ot_s, load_low_s, led_flt_s, ls_flt_s, sup_flt_s, bat_uv_s, bat_ov_s,
          vs_uv_s, lin_fail_s, lin_wake_s, cyc_exp_s, err_in_s, mon_s} = flt_s;

  // Frame edges; clock edges count only while selected
  assign cs_fall = cs_prev_q & ~cs_s;
  assign cs_rise = ~cs_prev_q & cs_s;
  assign sclk_rise = ~sclk_prev_q & sclk_s & ~cs_s;
  assign sclk_fall = sclk_prev_q & ~sclk_s & ~cs_s;
  assign frame_ok = cs_rise & (bit_cnt_q == `FRAME_CNT_W'(`FRAME_BITS));
  assign cw_mode = rx_q[`CW_MODE_HI:`CW_MODE_LO];
  assign cw_sel = cfg_sel_t'(rx_q[`CW_SEL_HI:`CW_SEL_LO]);

  // Mode qualifiers
  assign is_active = (mode_q == MODE_ACTIVE_S) || (mode_q == MODE_LIN_SLEEP_S);
  assign power_save = (mode_q == MODE_STOP_S) || (mode_q == MODE_SLEEP_S);
  assign vmon_ready = (vmon_cnt_q == VMON_W'(VMON_STARTUP_CYCLES));

  // Monitoring is only trusted in active and LIN sleep modes
  assign bat_uv_g = bat_uv_s & is_active & vmon_ready;
  assign bat_ov_g = bat_ov_s & is_active;
  assign vs_uv_g = vs_uv_s & is_active;

  // Own pulse on a switch fault would look like a controller error; ignore while faulting
  assign mcu_err = ~err_in_s & ~ls_flt_s;

  // Wake sources, counted only in the power saving modes
  assign mon_edge = (mon_s ^ mon_prev_q) & general_config[7:3];
  assign cyc_wake = cyc_exp_s & (mode_q == MODE_STOP_S) & (cyclic_period != 5'h00);
  assign any_wake = power_save & ((|mon_edge) | lin_wake_s | cyc_wake);

  // Edge history for chip select, serial clock, the switch fault and the monitor inputs
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      cs_prev_q <= 1'b1;
      sclk_prev_q <= 1'b0;
      mon_prev_q <= 5'h00;
      ls_flt_prev_q <= 1'b0;
    end else begin
      cs_prev_q <= cs_s;
      sclk_prev_q <= sclk_s;
      mon_prev_q <= mon_s;
      ls_flt_prev_q <= ls_flt_s;
    end
  end

  // Receive on falling edges, LSB first, count saturates above a frame
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      rx_q <= 16'h0000;
      bit_cnt_q <= '0;
    end else if (cs_fall) begin
      bit_cnt_q <= '0;
    end else if (sclk_fall) begin
      rx_q <= {din_s, rx_q[`FRAME_BITS-1:1]};
      if (bit_cnt_q != '1) begin
        bit_cnt_q <= bit_cnt_q + `FRAME_CNT_W'(1);
      end
    end
  end

  // A frame of the wrong length marks the serial failure indicator
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      spi_fail_q <= 1'b0;
    end else if (frame_ok) begin
      spi_fail_q <= 1'b0;
    end else if (cs_rise) begin
      spi_fail_q <= 1'b1;
    end
  end

  // Normal and wake-up views of the status word
  always_comb begin
    status_word = 16'h0000;
    status_word[`ST_PREWARN] = flag_q[`FL_PREWARN];
    status_word[`ST_LED] = flag_q[`FL_LED];
    status_word[`ST_VINT_OK] = vint_ok_q;
    status_word[`ST_LS] = flag_q[`FL_LS];
    status_word[`ST_WDRST] = flag_q[`FL_WDRST];
    status_word[`ST_SUPPLY] = flag_q[`FL_SUPPLY];
    if (wake_word_q) begin
      status_word[`ST_MON_HI:`ST_MON_LO] = wake_mon_q;
      status_word[`WK_LIN] = wake_lin_q;
      status_word[`WK_CYCLIC] = wake_cyc_q;
    end else begin
      status_word[`ST_MON_HI:`ST_MON_LO] = mon_s & general_config[7:3];
      status_word[`ST_LIN] = lin_fail_s;
      status_word[`ST_BAT_UV] = flag_q[`FL_BAT_UV];
      status_word[`ST_BAT_OV] = flag_q[`FL_BAT_OV];
      status_word[`ST_VS_UV] = flag_q[`FL_VS_UV];
    end
  end

  // Transmit: wake signal while deselected, failure indicator before the first clock
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      tx_q <= 16'h0000;
      shifting_q <= 1'b0;
      serial_data_out <= 1'b1;
      serial_data_out_oe_n <= 1'b1;
    end else if (cs_s) begin
      shifting_q <= 1'b0;
      serial_data_out <= ~wake_do_q;
      serial_data_out_oe_n <= ~wake_do_q;
    end else begin
      serial_data_out_oe_n <= 1'b0;
      if (cs_fall) begin
        tx_q <= status_word;
        serial_data_out <= spi_fail_q | din_s;
      end else if (sclk_rise) begin
        shifting_q <= 1'b1;
        serial_data_out <= tx_q[0];
        tx_q <= {1'b0, tx_q[`FRAME_BITS-1:1]};
      end else if (!shifting_q) begin
        serial_data_out <= spi_fail_q | din_s;
      end
    end
  end

  // Latched fault flags; all clear when the read-out frame closes
  assign flag_set = {window_guard_reset, vs_uv_g, bat_ov_g, bat_uv_g, sup_flt_s, ls_flt_s,
                     led_flt_s, prewarn_s};
  always_comb begin
    flag_clr = {`NUM_FLAGS{cs_rise}};
    if (mode_q == MODE_STANDBY_S) begin
      flag_clr[`FL_BAT_UV] = 1'b1;
      flag_clr[`FL_BAT_OV] = 1'b1;
    end
  end

  for (genvar i = 0; i < `NUM_FLAGS; i++) begin : g_flag
    sticky_flag u_flag (
      .ref_clk(ref_clk),
      .sys_rst(sys_rst),
      .set_evt(flag_set[i]),
      .clr_evt(flag_clr[i]),
      .flag_q(flag_q[i])
    );
  end

  // Supply-ok bit reads low after an internal reset until a full frame has reported it
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      vint_ok_q <= 1'b0;
    end else if (frame_ok) begin
      vint_ok_q <= 1'b1;
    end
  end

  // Voltage monitor start-up time, restarted on every entry into active or LIN sleep mode from a mode that is neither
  always_ff @(posedge ref_clk) begin
    if (sys_rst || !is_active) begin
      vmon_cnt_q <= '0;
    end else if (!vmon_ready) begin
      vmon_cnt_q <= vmon_cnt_q + VMON_W'(1);
    end
  end

  // Operating mode: guard reset beats wake, wake beats software
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      mode_q <= MODE_STANDBY_S;
    end else if (window_guard_reset || any_wake) begin
      mode_q <= MODE_STANDBY_S;
    end else if (frame_ok) begin
      unique case (cw_mode)
        `MODE_LIN_SLEEP: mode_q <= MODE_LIN_SLEEP_S;
        `MODE_ACTIVE: mode_q <= MODE_ACTIVE_S;
        `MODE_SLEEP: mode_q <= MODE_SLEEP_S;
        `MODE_RX_ONLY: mode_q <= MODE_RX_ONLY_S;
        `MODE_STOP: mode_q <= MODE_STOP_S;
        default: mode_q <= mode_q; // Reserved codes leave the mode alone
      endcase
    end
  end

  // Configuration written by complete frames, cleared only by reset
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      general_config <= 9'h000;
      cyclic_period <= 5'h00;
      window_guard_period <= 6'h00;
      led_ovuv_dis_q <= 1'b0;
      measure_en <= 1'b0;
      guard_lp_q <= 1'b0;
    end else if (frame_ok) begin
      measure_en <= rx_q[`CW_MEAS];
      guard_lp_q <= rx_q[`CW_GUARD_LP];
      unique case (cw_sel)
        SEL_GENERAL: general_config <= rx_q[`CW_CFG_HI:`CW_CFG_LO];
        SEL_SWITCH: led_ovuv_dis_q <= rx_q[`SW_LED_OVUV_DIS];
        SEL_CYCLIC: cyclic_period <= rx_q[`CYC_HI:`CW_CFG_LO];
        SEL_GUARD: window_guard_period <= rx_q[`GUARD_HI:`CW_CFG_LO];
      endcase
    end
  end

  // Guard trigger pulse on each accepted guard period write
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      window_guard_trigger <= 1'b0;
    end else begin
      window_guard_trigger <= frame_ok && (cw_sel == SEL_GUARD);
    end
  end

  // Low-side switches: faults and controller errors win over a same-cycle enable
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      low_side_switches_en <= 2'h0;
    end else if (ls_flt_s || mcu_err || window_guard_reset) begin
      low_side_switches_en <= 2'h0;
    end else if (!(is_active || mode_q == MODE_RX_ONLY_S)) begin
      low_side_switches_en <= 2'h0;
    end else if (frame_ok && cw_sel == SEL_SWITCH) begin
      low_side_switches_en <= rx_q[`SW_LS_HI:`SW_LS_LO];
    end
  end

  // Error link: one-cycle low pulse on the rising edge of a switch fault
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      error_link_out <= 1'b0;
      error_link_oe_n <= 1'b1;
    end else begin
      error_link_out <= 1'b0;
      error_link_oe_n <= ~(ls_flt_s & ~ls_flt_prev_q);
    end
  end

  // Sensor supply output
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      supply_output_en <= 1'b0;
    end else if (sup_flt_s || window_guard_reset) begin
      supply_output_en <= 1'b0;
    end else if (frame_ok && cw_sel == SEL_SWITCH) begin
      supply_output_en <= rx_q[`SW_SUPPLY];
    end
  end

  // LED driver; the battery shutdown can be masked by the switch option
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      led_driver_en <= 1'b0;
    end else if (led_flt_s || window_guard_reset) begin
      led_driver_en <= 1'b0;
    end else if ((bat_uv_g || bat_ov_g) && !led_ovuv_dis_q) begin
      led_driver_en <= 1'b0;
    end else if (frame_ok && cw_sel == SEL_SWITCH) begin
      led_driver_en <= rx_q[`SW_LED];
    end
  end

  // Regulator is off in sleep mode and otherwise follows its thermal comparator, which carries the hysteresis
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      regulator_en <= 1'b1;
    end else begin
      regulator_en <= ~reg_ot_s & (mode_q != MODE_SLEEP_S);
    end
  end

  // Guard stays on unless low power mode allows it to stop
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      window_guard_en <= 1'b1;
    end else if (mode_q == MODE_STOP_S) begin
      window_guard_en <= ~(load_low_s & ~guard_lp_q);
    end else if (mode_q == MODE_SLEEP_S) begin
      window_guard_en <= guard_lp_q;
    end else begin
      window_guard_en <= 1'b1;
    end
  end

  // Wake capture; sources held until the wake word has been shifted out
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      wake_word_q <= 1'b0;
      wake_read_q <= 1'b0;
      wake_mon_q <= 5'h00;
      wake_lin_q <= 1'b0;
      wake_cyc_q <= 1'b0;
    end else if (any_wake) begin
      wake_word_q <= 1'b1;
      wake_mon_q <= wake_mon_q | mon_edge;
      wake_lin_q <= wake_lin_q | lin_wake_s;
      wake_cyc_q <= wake_cyc_q | cyc_wake;
    end else if (cs_fall) begin
      wake_read_q <= wake_word_q;
    end else if (cs_rise && wake_read_q) begin
      wake_read_q <= 1'b0;
      wake_word_q <= 1'b0;
      wake_mon_q <= 5'h00;
      wake_lin_q <= 1'b0;
      wake_cyc_q <= 1'b0;
    end
  end

  // Wake signalling to the controller, dropped as soon as it selects the device
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      wake_do_q <= 1'b0;
      rxd_force_low <= 1'b0;
    end else if (any_wake) begin
      wake_do_q <= 1'b1;
      rxd_force_low <= rxd_force_low | lin_wake_s;
    end else if (cs_fall) begin
      wake_do_q <= 1'b0;
      rxd_force_low <= 1'b0;
    end
  end

  assign sbc_mode = mode_q;

endmodule : sbc_diag_status
`default_nettype wire

// [sbc_consts.svh]
// Bit positions, field layouts, codes and reset values of the diagnostic status block
`ifndef SBC_CONSTS_SVH
`define SBC_CONSTS_SVH

// Frame geometry
`define FRAME_BITS 16
`define FRAME_CNT_W 5

// Normal status word layout
`define ST_PREWARN 0
`define ST_LED 1
`define ST_VINT_OK 2
`define ST_LS 3
`define ST_WDRST 4
`define ST_MON_LO 5
`define ST_MON_HI 9
`define ST_RSVD 10
`define ST_LIN 11
`define ST_BAT_UV 12
`define ST_BAT_OV 13
`define ST_SUPPLY 14
`define ST_VS_UV 15

// Wake-up status word layout (bits 13 and 15 read zero, other bits shared with the normal word)
`define WK_LIN 11
`define WK_CYCLIC 12

// Control word layout
`define CW_MODE_LO 0
`define CW_MODE_HI 2
`define CW_SEL_LO 3
`define CW_SEL_HI 4
`define CW_CFG_LO 5
`define CW_CFG_HI 13
`define CW_MEAS 14
`define CW_GUARD_LP 15

// Integrated switch configuration fields
`define SW_SUPPLY 5
`define SW_LED 6
`define SW_LED_OVUV_DIS 7
`define SW_LS_LO 8
`define SW_LS_HI 9

// Period field tops
`define CYC_HI 9
`define GUARD_HI 10

// Mode codes as written by software
`define MODE_LIN_SLEEP 3'h2
`define MODE_ACTIVE 3'h3
`define MODE_SLEEP 3'h4
`define MODE_RX_ONLY 3'h6
`define MODE_STOP 3'h7

// Pin reset levels: {chip select, serial clock, data in}
`define SPI_PINS_RST 3'h4
// Fault pins reset levels; error link idles high
`define FAULT_PINS_RST 18'h00020

// Latched flag indices
`define NUM_FLAGS 8
`define FL_PREWARN 0
`define FL_LED 1
`define FL_LS 2
`define FL_SUPPLY 3
`define FL_BAT_UV 4
`define FL_BAT_OV 5
`define FL_VS_UV 6
`define FL_WDRST 7

`endif

// [sbc_pkg.sv]
// Types shared by the diagnostic status block
`default_nettype none
package sbc_pkg;

  // Operating modes, Gray coded along standby -> active -> LIN sleep -> RX only -> stop -> sleep
  typedef enum logic [2:0] {
    MODE_STANDBY_S = 3'h0,
    MODE_ACTIVE_S = 3'h1,
    MODE_LIN_SLEEP_S = 3'h3,
    MODE_RX_ONLY_S = 3'h2,
    MODE_STOP_S = 3'h6,
    MODE_SLEEP_S = 3'h7
  } sbc_mode_t;

  // Configuration selector of the control word
  typedef enum logic [1:0] {
    SEL_GENERAL = 2'h0,
    SEL_SWITCH = 2'h1,
    SEL_CYCLIC = 2'h2,
    SEL_GUARD = 2'h3
  } cfg_sel_t;

endpackage : sbc_pkg
`default_nettype wire

// [pin_sync.sv]
// Three-stage pin synchroniser that accepts a change once stages two and three agree
`timescale 1ns/10ps
`default_nettype none
module pin_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] level_q
);

  logic [WIDTH-1:0] s1_q;
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;

  // Stage one feeds stage two only; the filter looks at two and three
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      s1_q <= RST_VAL;
      s2_q <= RST_VAL;
      s3_q <= RST_VAL;
      level_q <= RST_VAL;
    end else begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      level_q <= (~(s2_q ^ s3_q) & s3_q) | ((s2_q ^ s3_q) & level_q);
    end
  end

endmodule : pin_sync
`default_nettype wire

// [sticky_flag.sv]
// One latched status flag: hardware sets it, the end of a read-out clears it
`timescale 1ns/10ps
`default_nettype none
module sticky_flag (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic set_evt,
  input wire logic clr_evt,
  output logic flag_q
);

  // Set beats clear so an event landing on the clear cycle survives
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      flag_q <= 1'b0;
    end else if (set_evt) begin
      flag_q <= 1'b1;
    end else if (clr_evt) begin
      flag_q <= 1'b0;
    end
  end

endmodule : sticky_flag
`default_nettype wire

// [sbc_diag_status_assertions.sv]
// Concurrent checks on fault reactions, error link and wake signalling of the status block
`timescale 1ns/10ps
`default_nettype none
module sbc_diag_checker
  import sbc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic low_side_switches_fault,
  input wire logic supply_output_fault,
  input wire logic led_driver_fault,
  input wire logic regulator_overtemp,
  input wire logic regulator_load_low,
  input wire logic error_link_in,
  input wire logic error_link_oe_n,
  input wire logic [1:0] low_side_switches_en,
  input wire logic supply_output_en,
  input wire logic led_driver_en,
  input wire logic regulator_en,
  input wire logic window_guard_en,
  input wire logic rxd_force_low,
  input wire logic serial_data_out,
  input wire logic serial_data_out_oe_n,
  input wire logic [2:0] sbc_mode
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  // Bounds allow for the three-stage pin filter plus one register
  a_err_pulse_len: assert property ($fell(error_link_oe_n) |=> error_link_oe_n)
    else $error("error link pulled longer than one cycle");
  a_err_pulse_off: assert property ($fell(error_link_oe_n) |->
    ##[0:3] low_side_switches_en == 2'h0)
    else $error("error link pulled without switches off");
  a_ls_fault_off: assert property ($rose(low_side_switches_fault) |->
    ##[1:8] low_side_switches_en == 2'h0)
    else $error("switches stay on after fault");
  a_err_in_off: assert property ($fell(error_link_in) && error_link_oe_n |->
    ##[1:8] low_side_switches_en == 2'h0)
    else $error("switches stay on after controller error");
  a_supply_fault_off: assert property ($rose(supply_output_fault) |->
    ##[1:8] !supply_output_en)
    else $error("supply output stays on after fault");
  a_led_fault_off: assert property ($rose(led_driver_fault) |-> ##[1:8] !led_driver_en)
    else $error("led driver stays on after fault");
  a_reg_hot_off: assert property ($rose(regulator_overtemp) |-> ##[1:8] !regulator_en)
    else $error("regulator stays on when hot");
  a_reg_cool_on: assert property ($fell(regulator_overtemp) && sbc_mode != MODE_SLEEP_S |->
    ##[1:8] regulator_en)
    else $error("regulator not restored after cooling");
  a_guard_stop_load: assert property ((sbc_mode == MODE_STOP_S && !regulator_load_low) [*6]
    |-> window_guard_en)
    else $error("guard dropped in stop with high load");
  a_bus_wake_low: assert property ($rose(rxd_force_low) |->
    ##[0:2] !serial_data_out_oe_n && !serial_data_out)
    else $error("bus wake not shown on data out");
endmodule : sbc_diag_checker
bind sbc_diag_status sbc_diag_checker chk_u (.ref_clk, .sys_rst, .low_side_switches_fault,
  .supply_output_fault, .led_driver_fault, .regulator_overtemp, .regulator_load_low,
  .error_link_in, .error_link_oe_n, .low_side_switches_en, .supply_output_en, .led_driver_en,
  .regulator_en, .window_guard_en, .rxd_force_low, .serial_data_out, .serial_data_out_oe_n,
  .sbc_mode);
`default_nettype wire

// [spi_master_model.sv]
// Controller-side serial master that frames words LSB first
`timescale 1ns/10ps
`default_nettype none
module spi_master_model (
  input wire logic ref_clk,
  input wire logic sdo,
  input wire logic sdo_oe_n,
  output logic cs_n,
  output logic sck,
  output logic sdi
);
  logic pre;
  logic line;
  // A released data-out line reads as the inverse, so a floating pin never looks valid
  assign line = sdo_oe_n ? ~sdo : sdo;
  initial begin
    cs_n = 1'b1;
    sck = 1'b0;
    sdi = 1'b0;
  end
  // Six cycles per level, longer than the design's pin filter needs
  task automatic hold();
    repeat (6) @(posedge ref_clk);
  endtask : hold
  // Callers repeat a read when one frame cannot confirm a flag
  task automatic xfer(input logic [15:0] wr, input int bits, output logic [15:0] rd);
    rd = 16'h0000;
    cs_n <= 1'b0;
    sdi <= 1'b0;
    hold();
    hold();
    pre = line;
    for (int i = 0; i < bits; i++) begin
      sdi <= wr[i];
      sck <= 1'b1;
      hold();
      rd[i] = line;
      sck <= 1'b0;
      hold();
    end
    cs_n <= 1'b1;
    hold();
    hold();
  endtask : xfer
endmodule : spi_master_model
`default_nettype wire

// [tb_top.sv]
// Self-checking testbench of the diagnostic status block
`timescale 1ns/10ps
`include "sbc_consts.svh"
`default_nettype none
module tb_top;
  import sbc_pkg::*;
  localparam logic [15:0] SW_ON = 16'h036b; // Active, switch config, all outputs on
  localparam logic [15:0] GEN_ACT = 16'h1f03; // Active, all monitors enabled
  localparam logic [15:0] GEN_STOP = 16'h1f07; // Stop, all monitors enabled
  localparam logic [15:0] VOK = 16'h1 << `ST_VINT_OK;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic mcu_err_n = 1'b1;
  logic chip_select_low, serial_clock, serial_data_in, serial_data_out, serial_data_out_oe_n;
  logic rxd_force_low, error_link_in, error_link_out, error_link_oe_n, regulator_prewarn;
  logic regulator_overtemp, regulator_load_low, led_driver_fault, low_side_switches_fault;
  logic supply_output_fault, battery_uv, battery_ov, supply_pin_uv, lin_failure, lin_wake;
  logic cyclic_wake_expired, window_guard_reset, supply_output_en, led_driver_en;
  logic regulator_en, window_guard_en;
  logic [4:0] monitor_input;
  logic [1:0] low_side_switches_en;
  logic [2:0] sbc_mode;
  logic [8:0] general_config;
  logic [15:0] rd;
  int err_total = 0;
  int checks = 0;
  // Free-running clock and the open-drain error link shared with the controller
  always #4 ref_clk = ~ref_clk;
  assign error_link_in = mcu_err_n & (error_link_oe_n | error_link_out);
  sbc_diag_status #(.VMON_STARTUP_CYCLES(8)) dut_u (.ref_clk, .sys_rst, .chip_select_low,
    .serial_clock, .serial_data_in, .serial_data_out, .serial_data_out_oe_n, .rxd_force_low,
    .error_link_in, .error_link_out, .error_link_oe_n, .regulator_prewarn, .regulator_overtemp,
    .regulator_load_low, .led_driver_fault, .low_side_switches_fault, .supply_output_fault,
    .battery_uv, .battery_ov, .supply_pin_uv, .lin_failure, .lin_wake, .cyclic_wake_expired,
    .monitor_input, .window_guard_reset, .low_side_switches_en, .supply_output_en,
    .led_driver_en, .regulator_en, .window_guard_en, .window_guard_trigger(),
    .window_guard_period(), .cyclic_period(), .general_config, .measure_en(), .sbc_mode);
  spi_master_model mdl_u (.ref_clk, .sdo(serial_data_out), .sdo_oe_n(serial_data_out_oe_n),
    .cs_n(chip_select_low), .sck(serial_clock), .sdi(serial_data_in));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wait_n(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : wait_n
  task automatic rd16(input logic [15:0] w);
    mdl_u.xfer(w, 16, rd);
  endtask : rd16
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : end_sim
  task automatic t_reset();
    chk({regulator_en, window_guard_en, low_side_switches_en, supply_output_en}, 5'h18);
    chk(sbc_mode, MODE_STANDBY_S);
    rd16(SW_ON);
    chk(rd, 16'h0000);
    // Low-side switch bits only take once the mode is already active, LIN sleep or RX only when the frame ends
    chk({low_side_switches_en, supply_output_en, led_driver_en, sbc_mode}, 7'h19);
    rd16(SW_ON);
    chk(rd, VOK);
    chk({low_side_switches_en, supply_output_en, led_driver_en, sbc_mode}, 7'h79);
    $display("test reset done");
  endtask : t_reset
  task automatic t_flags();
    regulator_prewarn <= 1'b1;
    monitor_input <= 5'h15;
    wait_n(8);
    regulator_prewarn <= 1'b0;
    rd16(GEN_ACT);
    chk(rd, VOK | 16'h0001);
    chk(general_config, 9'h0f8);
    rd16(GEN_ACT);
    chk(rd, VOK | 16'h02a0);
    lin_failure <= 1'b1;
    rd16(GEN_ACT);
    chk(rd[`ST_LIN], 1'b1);
    lin_failure <= 1'b0;
    rd16(GEN_ACT);
    chk(rd[`ST_LIN], 1'b0);
    $display("test flags done");
  endtask : t_flags
  task automatic t_faults();
    low_side_switches_fault <= 1'b1;
    supply_output_fault <= 1'b1;
    led_driver_fault <= 1'b1;
    wait_n(10);
    chk({low_side_switches_en, supply_output_en, led_driver_en}, 4'h0);
    {low_side_switches_fault, supply_output_fault, led_driver_fault} <= 3'h0;
    rd16(SW_ON);
    chk(rd & 16'h400a, 16'h400a);
    mcu_err_n <= 1'b0;
    wait_n(10);
    chk(low_side_switches_en, 2'h0);
    mcu_err_n <= 1'b1;
    {battery_ov, supply_pin_uv} <= 2'h3;
    rd16(SW_ON);
    chk(led_driver_en, 1'b0);
    {battery_ov, supply_pin_uv} <= 2'h0;
    rd16(SW_ON);
    chk(rd[`ST_BAT_OV], 1'b1);
    chk(rd[`ST_VS_UV], 1'b1);
    $display("test faults done");
  endtask : t_faults
  task automatic t_guard();
    regulator_overtemp <= 1'b1;
    wait_n(10);
    chk(regulator_en, 1'b0);
    regulator_overtemp <= 1'b0;
    wait_n(10);
    chk(regulator_en, 1'b1);
    window_guard_reset <= 1'b1;
    wait_n(1);
    window_guard_reset <= 1'b0;
    battery_ov <= 1'b1;
    rd16(SW_ON);
    chk(rd[`ST_WDRST], 1'b1);
    chk(rd[`ST_BAT_OV], 1'b0);
    battery_ov <= 1'b0;
    rd16(SW_ON);
    chk(rd[`ST_WDRST], 1'b0);
    mdl_u.xfer(GEN_STOP, 8, rd);
    rd16(GEN_ACT);
    chk(mdl_u.pre, 1'b1);
    rd16(GEN_ACT);
    chk(mdl_u.pre, 1'b0);
    $display("test guard done");
  endtask : t_guard
  task automatic t_wake();
    rd16(GEN_STOP);
    regulator_load_low <= 1'b1;
    wait_n(10);
    chk(window_guard_en, 1'b0);
    regulator_load_low <= 1'b0;
    lin_wake <= 1'b1;
    wait_n(10);
    chk({rxd_force_low, serial_data_out_oe_n, serial_data_out, sbc_mode}, 6'h20);
    lin_wake <= 1'b0;
    rd16(GEN_ACT);
    chk(rd & 16'hbbe0, 16'h0800);
    chk(rxd_force_low, 1'b0);
    rd16(GEN_STOP);
    monitor_input <= 5'h14;
    wait_n(10);
    chk({serial_data_out_oe_n, serial_data_out}, 2'h0);
    rd16(GEN_ACT);
    chk(rd[9:5], 5'h01);
    $display("test wake done");
  endtask : t_wake
  // Main sequence: reset for two cycles, then each scenario in turn
  initial begin
    {regulator_prewarn, regulator_overtemp, regulator_load_low, led_driver_fault,
      low_side_switches_fault, supply_output_fault, battery_uv, battery_ov, supply_pin_uv,
      lin_failure, lin_wake, cyclic_wake_expired, window_guard_reset} = 13'h0000;
    monitor_input = 5'h00;
    wait_n(2);
    sys_rst <= 1'b0;
    wait_n(4);
    t_reset();
    t_flags();
    t_faults();
    t_guard();
    t_wake();
    end_sim();
  end
endmodule : tb_top
`default_nettype wire
